// ### hw/vafe_ctrl.sv
/*
  Sync selection, copy-protection masking, staged gain, bandwidth, peaking
  and offset control for a three-channel video front end, with an Avalon-MM
  register slave.
  Assumes the copy-protection detector, clamp pulse and sync inputs are
  synchronous to clk; analog blocks consume the registered outputs.
*/
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "vafe_defs.svh"

module vafe_ctrl #(
  parameter int GAIN_TIMEOUT_CYC = `VAFE_GAIN_TIMEOUT_CYC
) (
  input  wire logic                     clk,
  input  wire logic                     srst,
  input  wire logic [7:0]               avs_address,
  input  wire logic                     avs_read,
  input  wire logic                     avs_write,
  input  wire logic [31:0]              avs_writedata,
  input  wire logic [3:0]               avs_byteenable,
  output logic [31:0]                   avs_readdata,
  output logic                          avs_waitrequest,
  input  wire vafe_pkg::vafe_sync_in_type sync_in,
  input  wire logic                     clamp_pulse,
  input  wire logic                     hsync_trailing,
  output vafe_pkg::vafe_sync_out_type   sync_out,
  output vafe_pkg::vafe_gain_type       gain_active,
  output vafe_pkg::vafe_offset_type     offset_ctl,
  output vafe_pkg::vafe_analog_type     analog_ctl
);

  logic [7:0]              input_cfg_q;
  logic [7:0]              red_off_q;
  logic [7:0]              green_off_q;
  logic [7:0]              blue_off_q;
  logic [7:0]              off_low_q;
  logic [7:0]              bandwidth_q;
  logic [7:0]              clk_src_q;
  logic [7:0]              black_ctrl_q;
  logic [7:0]              dpll_gain_q;
  vafe_pkg::vafe_gain_type gain_stage_q;
  logic                    gain_pending_q;
  logic [31:0]             timeout_q;
  logic                    ack_q;
  logic                    req;
  logic                    wr_en;
  logic [7:0]              wdat;
  logic [31:0]             rdat_d;
  logic                    mask_en;
  logic                    sel_sync;
  logic                    gain_load;

  // One wait cycle; a write lands only at the edge that sees waitrequest low
  assign req   = (avs_read | avs_write) & ~ack_q;
  assign wr_en = avs_write & ack_q & avs_byteenable[0];
  assign wdat  = avs_writedata[7:0];

  always_ff @(posedge clk) begin
    if (srst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~req;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      input_cfg_q  <= `VAFE_RST_ZERO;
      red_off_q    <= `VAFE_RST_OFFSET;
      green_off_q  <= `VAFE_RST_OFFSET;
      blue_off_q   <= `VAFE_RST_OFFSET;
      off_low_q    <= `VAFE_RST_ZERO;
      bandwidth_q  <= `VAFE_RST_BANDWIDTH;
      clk_src_q    <= `VAFE_RST_ZERO;
      black_ctrl_q <= `VAFE_RST_ZERO;
      dpll_gain_q  <= `VAFE_RST_DPLL_GAIN;
    end else if (wr_en) begin
      case (avs_address)
        `VAFE_OFS_INPUT_CFG:  input_cfg_q  <= wdat;
        `VAFE_OFS_RED_OFF:    red_off_q    <= wdat;
        `VAFE_OFS_GREEN_OFF:  green_off_q  <= wdat;
        `VAFE_OFS_BLUE_OFF:   blue_off_q   <= wdat;
        `VAFE_OFS_OFF_LOW:    off_low_q    <= wdat;
        `VAFE_OFS_BANDWIDTH:  bandwidth_q  <= wdat;
        `VAFE_OFS_CLK_SRC:    clk_src_q    <= wdat;
        `VAFE_OFS_BLACK_CTRL: black_ctrl_q <= wdat;
        `VAFE_OFS_DPLL_GAIN:  dpll_gain_q  <= wdat;
        default: ;
      endcase
    end
  end

  // Gain writes land in staging only, never straight on the amplifier
  always_ff @(posedge clk) begin
    if (srst) begin
      gain_stage_q <= {`VAFE_RST_GAIN, `VAFE_RST_GAIN, `VAFE_RST_GAIN};
    end else if (wr_en) begin
      case (avs_address)
        `VAFE_OFS_RED_GAIN:   gain_stage_q.red   <= wdat;
        `VAFE_OFS_GREEN_GAIN: gain_stage_q.green <= wdat;
        `VAFE_OFS_BLUE_GAIN:  gain_stage_q.blue  <= wdat;
        default: ;
      endcase
    end
  end

  // Without clamps the timeout forces the copy so a write is never stuck
  assign gain_load = clamp_pulse | (timeout_q == 32'(GAIN_TIMEOUT_CYC - 1));

  always_ff @(posedge clk) begin
    if (srst) begin
      gain_pending_q <= 1'b0;
    end else if (wr_en && avs_address >= `VAFE_OFS_RED_GAIN &&
                 avs_address <= `VAFE_OFS_BLUE_GAIN) begin
      gain_pending_q <= 1'b1;                                  // Write wins over load
    end else if (gain_load) begin
      gain_pending_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !gain_pending_q || gain_load) begin
      timeout_q <= 32'h0000_0000;
    end else begin
      timeout_q <= timeout_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      gain_active <= {`VAFE_RST_GAIN, `VAFE_RST_GAIN, `VAFE_RST_GAIN};
    end else if (gain_load) begin
      gain_active <= gain_stage_q;
    end
  end

  always_comb begin
    rdat_d = 32'h0000_0000;
    case (avs_address)
      `VAFE_OFS_INPUT_CFG:  rdat_d[7:0] = input_cfg_q;
      `VAFE_OFS_RED_GAIN:   rdat_d[7:0] = gain_stage_q.red;
      `VAFE_OFS_GREEN_GAIN: rdat_d[7:0] = gain_stage_q.green;
      `VAFE_OFS_BLUE_GAIN:  rdat_d[7:0] = gain_stage_q.blue;
      `VAFE_OFS_RED_OFF:    rdat_d[7:0] = red_off_q;
      `VAFE_OFS_GREEN_OFF:  rdat_d[7:0] = green_off_q;
      `VAFE_OFS_BLUE_OFF:   rdat_d[7:0] = blue_off_q;
      `VAFE_OFS_OFF_LOW:    rdat_d[7:0] = off_low_q;
      `VAFE_OFS_BANDWIDTH:  rdat_d[7:0] = bandwidth_q;
      `VAFE_OFS_CLK_SRC:    rdat_d[7:0] = clk_src_q;
      `VAFE_OFS_BLACK_CTRL: rdat_d[7:0] = black_ctrl_q;
      `VAFE_OFS_DPLL_GAIN:  rdat_d[7:0] = dpll_gain_q;
      `VAFE_OFS_STATUS:     rdat_d[3:0] = {gain_pending_q, sync_in.copy_protect_det,
                                           sync_out.pll_sync, sync_out.hsync_out};
      default:              rdat_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (req) begin
      avs_readdata <= rdat_d;
    end
  end

  // Sync source select; an undefined code falls back to separate sync
  always_comb begin
    case (vafe_pkg::vafe_sync_sel_type'(
          input_cfg_q[`VAFE_BIT_SYNC_SEL_HI:`VAFE_BIT_SYNC_SEL_LO]))
      vafe_pkg::VAFE_SYNC_CSYNC_HS: sel_sync = sync_in.raw_hsync;
      vafe_pkg::VAFE_SYNC_GREEN:    sel_sync = sync_in.green_channel_sync;
      default:                      sel_sync = sync_in.raw_hsync;
    endcase
  end

  // Mask only while the detector flags protection and a pulse is present
  assign mask_en = sync_in.copy_protect_det & sync_in.cp_pulse &
                   ~input_cfg_q[`VAFE_BIT_MASK_DIS];

  always_ff @(posedge clk) begin
    if (srst) begin
      sync_out.pll_sync <= 1'b0;
    end else begin
      sync_out.pll_sync <= sel_sync & ~mask_en;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sync_out.hsync_out <= 1'b0;
    end else begin
      sync_out.hsync_out <= sel_sync &
                            ~(mask_en & ~input_cfg_q[`VAFE_BIT_HS_MASK_DIS]);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sync_out.vsync_out <= 1'b0;
    end else begin
      sync_out.vsync_out <= sync_in.raw_vsync;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      analog_ctl <= '0;
    end else begin
      analog_ctl.bw_corner     <= bandwidth_q[3:1];
      analog_ctl.peaking       <= bandwidth_q[7:4];
      analog_ctl.ext_pixel_clk <= (clk_src_q[`VAFE_BIT_CLK_HI:`VAFE_BIT_CLK_LO]
                                   == `VAFE_CLK_EXTERNAL);
      analog_ctl.loop_run      <= hsync_trailing &
                                  ~black_ctrl_q[`VAFE_BIT_LOOP_OFF];
      analog_ctl.dpll_gain     <= dpll_gain_q;
    end
  end

  // Loop on: DAC is the loop's, registers become digital adders
  always_ff @(posedge clk) begin
    if (srst) begin
      offset_ctl <= '0;
    end else begin
      offset_ctl.loop_on    <= ~black_ctrl_q[`VAFE_BIT_LOOP_OFF];
      offset_ctl.range_half <= off_low_q[`VAFE_BIT_RANGE];
      offset_ctl.red_digital   <= black_ctrl_q[0] ? 8'h00 : red_off_q;
      offset_ctl.green_digital <= black_ctrl_q[0] ? 8'h00 : green_off_q;
      offset_ctl.blue_digital  <= black_ctrl_q[0] ? 8'h00 : blue_off_q;
      offset_ctl.red_dac   <= {red_off_q,   off_low_q[7:6]};
      offset_ctl.green_dac <= {green_off_q, off_low_q[5:4]};
      offset_ctl.blue_dac  <= {blue_off_q,  off_low_q[3:2]};
    end
  end

  dpll_reset_a: assert property (@(posedge clk) $fell(srst) |=>
      analog_ctl.dpll_gain == `VAFE_RST_DPLL_GAIN)
    else $error("dpll gain reset value wrong");

  gain_staged_a: assert property (@(posedge clk) disable iff (srst)
      !gain_load |=> $stable(gain_active))
    else $error("gain changed without load");

  gain_clamp_a: assert property (@(posedge clk) disable iff (srst)
      clamp_pulse |=> gain_active == $past(gain_stage_q))
    else $error("gain not loaded on clamp");

  gain_timeout_a: assert property (@(posedge clk) disable iff (srst)
      timeout_q < 32'(GAIN_TIMEOUT_CYC))
    else $error("gain timeout overrun");

  pll_mask_a: assert property (@(posedge clk) disable iff (srst)
      mask_en |=> !sync_out.pll_sync)
    else $error("masked sync reached pll");

  mask_off_a: assert property (@(posedge clk) disable iff (srst)
      !sync_in.copy_protect_det |=> sync_out.pll_sync == $past(sel_sync))
    else $error("sync altered without detection");

  hs_pass_a: assert property (@(posedge clk) disable iff (srst)
      input_cfg_q[7] |=> sync_out.hsync_out == $past(sel_sync))
    else $error("hsync output masked while unmasked");

  bw_map_a: assert property (@(posedge clk) disable iff (srst)
      1'b1 |=> analog_ctl.bw_corner == $past(bandwidth_q[3:1]))
    else $error("bandwidth corner wrong");

  dac_map_a: assert property (@(posedge clk) disable iff (srst)
      1'b1 |=> offset_ctl.red_dac[9:2] == $past(red_off_q))
    else $error("dac high bits wrong");

  wait_one_a: assert property (@(posedge clk) disable iff (srst)
      req |=> !avs_waitrequest) 
    else $error("waitrequest not released");

  // Bus side: writes and read data belong to the waitrequest-low edge
  wr_ack_a: assert property (@(posedge clk) disable iff (srst)
      wr_en |->
      !avs_waitrequest)
    else $error("write landed while waitrequest high");

  rd_data_a: assert property (@(posedge clk) disable iff (srst)
      avs_read && ack_q |->
      avs_readdata == $past(rdat_d))
    else $error("read data not standing at acknowledge");

  gain_reset_a: assert property (@(posedge clk)
      $fell(srst) |->
      gain_active == {`VAFE_RST_GAIN, `VAFE_RST_GAIN, `VAFE_RST_GAIN})
    else $error("gain reset value wrong");

  bw_reset_a: assert property (@(posedge clk)
      $fell(srst) |->
      bandwidth_q == `VAFE_RST_BANDWIDTH)
    else $error("bandwidth reset value wrong");

  pending_set_a: assert property (@(posedge clk) disable iff (srst)
      wr_en && avs_address inside {[`VAFE_OFS_RED_GAIN:`VAFE_OFS_BLUE_GAIN]} |=>
      gain_pending_q)
    else $error("gain write not staged");

  // Sync path
  green_sel_a: assert property (@(posedge clk) disable iff (srst)
      input_cfg_q[`VAFE_BIT_SYNC_SEL_HI:`VAFE_BIT_SYNC_SEL_LO] == 2'h2 |->
      sel_sync == sync_in.green_channel_sync)
    else $error("green sync not selected");

  vsync_pass_a: assert property (@(posedge clk) disable iff (srst)
      1'b1 |=>
      sync_out.vsync_out == $past(sync_in.raw_vsync))
    else $error("vsync output wrong");

  mask_dis_a: assert property (@(posedge clk) disable iff (srst)
      input_cfg_q[`VAFE_BIT_MASK_DIS] |=>
      sync_out.pll_sync == $past(sel_sync))
    else $error("sync masked while mask disabled");

  hs_mask_a: assert property (@(posedge clk) disable iff (srst)
      mask_en && !input_cfg_q[`VAFE_BIT_HS_MASK_DIS] |=>
      !sync_out.hsync_out)
    else $error("masked pulse reached hsync output");

  // Analog controls
  peak_map_a: assert property (@(posedge clk) disable iff (srst)
      1'b1 |=>
      analog_ctl.peaking == $past(bandwidth_q[7:4]))
    else $error("peaking field wrong");

  ext_clk_a: assert property (@(posedge clk) disable iff (srst)
      1'b1 |=>
      analog_ctl.ext_pixel_clk == ($past(clk_src_q[5:4]) == `VAFE_CLK_EXTERNAL))
    else $error("external clock select wrong");

  dpll_map_a: assert property (@(posedge clk) disable iff (srst)
      1'b1 |=>
      analog_ctl.dpll_gain == $past(dpll_gain_q))
    else $error("dpll gain output wrong");

  loop_trig_a: assert property (@(posedge clk) disable iff (srst)
      hsync_trailing && !black_ctrl_q[`VAFE_BIT_LOOP_OFF] |=>
      analog_ctl.loop_run)
    else $error("loop not run after trailing edge");

  loop_run_a: assert property (@(posedge clk) disable iff (srst)
      analog_ctl.loop_run |->
      offset_ctl.loop_on)
    else $error("loop run while loop disabled");

  // Offset paths
  digital_on_a: assert property (@(posedge clk) disable iff (srst)
      !black_ctrl_q[`VAFE_BIT_LOOP_OFF] |=> {offset_ctl.red_digital, offset_ctl.green_digital,
      offset_ctl.blue_digital} == $past({red_off_q, green_off_q, blue_off_q}))
    else $error("digital offset wrong");

  digital_off_a: assert property (@(posedge clk) disable iff (srst)
      !offset_ctl.loop_on |-> {offset_ctl.red_digital, offset_ctl.green_digital,
      offset_ctl.blue_digital} == 24'h000000)
    else $error("digital offset active with loop off");

  range_map_a: assert property (@(posedge clk) disable iff (srst)
      1'b1 |=>
      offset_ctl.range_half == $past(off_low_q[`VAFE_BIT_RANGE]))
    else $error("offset range bit wrong");

  dac_low_a: assert property (@(posedge clk) disable iff (srst)
      1'b1 |=> {offset_ctl.red_dac[1:0], offset_ctl.green_dac[1:0],
      offset_ctl.blue_dac[1:0]} == $past(off_low_q[7:2]))
    else $error("dac low bits wrong");

  cp_mask_c: cover property (@(posedge clk) disable iff (srst) mask_en);
  gain_load_c: cover property (@(posedge clk) disable iff (srst) gain_load && gain_pending_q);
  ext_clk_c: cover property (@(posedge clk) disable iff (srst) analog_ctl.ext_pixel_clk);
  hs_pass_c: cover property (@(posedge clk) disable iff (srst)
      mask_en && input_cfg_q[`VAFE_BIT_HS_MASK_DIS]);
  loop_off_c: cover property (@(posedge clk) disable iff (srst) !offset_ctl.loop_on);

endmodule // vafe_ctrl

// ### hw/vafe_defs.svh
/*
  Register offsets, field positions, reset values and timing counts for the
  video front-end sync, gain and offset control block.
  Assumes a 100 MHz system clock and word-aligned Avalon-MM register access.
*/
// Overview of operation
// - Select sync from three sources
// - Mask copy-protection pulses on green sync to PLL
// - Input config bit 6 disables sync mask
// - Mask also applied to horizontal sync output
// - Input config bit 7 unmasks hsync output only
// - DPLL gain register resets to 0x49
// - Gain equals 0.5 plus code over 170
// - Gain applied by clamp pulse once per line
// - Without sync, gain applied within 100 ms
// - Bandwidth bits 3:1 select eight corners
// - Bandwidth bits 7:4 select peaking zero
// - Loop on: offsets are digital adders
// - Loop off: offsets drive 10-bit DAC
// - Range bit halves offset DAC swing
// - Manual step sizes follow range bit
// - Loop enabled when control bit 0 is 0
// - Clock source 11 selects external pixel clock
`ifndef VAFE_DEFS_SVH
`define VAFE_DEFS_SVH

`define VAFE_OFS_INPUT_CFG   8'h05
`define VAFE_OFS_RED_GAIN    8'h06
`define VAFE_OFS_GREEN_GAIN  8'h07
`define VAFE_OFS_BLUE_GAIN   8'h08
`define VAFE_OFS_RED_OFF     8'h09
`define VAFE_OFS_GREEN_OFF   8'h0A
`define VAFE_OFS_BLUE_OFF    8'h0B
`define VAFE_OFS_OFF_LOW     8'h0C
`define VAFE_OFS_BANDWIDTH   8'h0D
`define VAFE_OFS_CLK_SRC     8'h13
`define VAFE_OFS_BLACK_CTRL  8'h17
`define VAFE_OFS_DPLL_GAIN   8'h1C
`define VAFE_OFS_STATUS      8'h30

`define VAFE_BIT_SYNC_SEL_LO 3
`define VAFE_BIT_SYNC_SEL_HI 4
`define VAFE_BIT_MASK_DIS    6
`define VAFE_BIT_HS_MASK_DIS 7
`define VAFE_BIT_RANGE       0
`define VAFE_BIT_LOOP_OFF    0
`define VAFE_BIT_CLK_LO      4
`define VAFE_BIT_CLK_HI      5

`define VAFE_RST_DPLL_GAIN   8'h49
`define VAFE_RST_BANDWIDTH   8'h0E
`define VAFE_RST_GAIN        8'h55
`define VAFE_RST_OFFSET      8'h80
`define VAFE_RST_ZERO        8'h00
`define VAFE_CLK_EXTERNAL    2'h3

`define VAFE_CLK_MHZ         100
`define VAFE_GAIN_TIMEOUT_MS 100
`define VAFE_GAIN_TIMEOUT_CYC (`VAFE_GAIN_TIMEOUT_MS * 1000 * `VAFE_CLK_MHZ)

`endif

// ### hw/vafe_pkg.sv
/*
  Types for the video front-end control block.
  Assumes vafe_defs.svh is compiled alongside.
*/
package vafe_pkg;

  typedef enum logic [1:0] {
    VAFE_SYNC_SEPARATE = 2'h0,
    VAFE_SYNC_CSYNC_HS = 2'h1,
    VAFE_SYNC_GREEN    = 2'h2
  } vafe_sync_sel_type;

  typedef struct packed {
    logic       raw_hsync;
    logic       raw_vsync;
    logic       green_channel_sync;
    logic       copy_protect_det;
    logic       cp_pulse;
  } vafe_sync_in_type;

  typedef struct packed {
    logic       pll_sync;
    logic       hsync_out;
    logic       vsync_out;
  } vafe_sync_out_type;

  typedef struct packed {
    logic [7:0] red;
    logic [7:0] green;
    logic [7:0] blue;
  } vafe_gain_type;

  typedef struct packed {
    logic       loop_on;
    logic       range_half;
    logic [9:0] red_dac;
    logic [9:0] green_dac;
    logic [9:0] blue_dac;
    logic [7:0] red_digital;
    logic [7:0] green_digital;
    logic [7:0] blue_digital;
  } vafe_offset_type;

  typedef struct packed {
    logic [2:0] bw_corner;
    logic [3:0] peaking;
    logic       ext_pixel_clk;
    logic       loop_run;
    logic [7:0] dpll_gain;
  } vafe_analog_type;

endpackage

// ### bench/vafe_src_model.sv
/*
  Video source model: random sync lines, copy-protection pulses, and the
  clamp and trailing-edge pulses once per line.
  Assumes the bench seeds $urandom; run low stops the lines (no sync at all).
*/
`timescale 1ns/1ps
module vafe_src_model #(
  parameter int LINE = 16
) (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic                  run,
  input  wire logic                  cp_en,
  output vafe_pkg::vafe_sync_in_type sync_in = '0,
  output logic                       clamp_pulse = 1'b0,
  output logic                       hsync_trailing = 1'b0
);
  int pos_q = 0;
  always @(posedge clk) begin
    if (srst || !run) begin
      pos_q          <= 0;
      sync_in        <= '0;
      clamp_pulse    <= 1'b0;
      hsync_trailing <= 1'b0;
    end else begin
      pos_q                      <= (pos_q == LINE - 1) ? 0 : pos_q + 1;
      sync_in.raw_hsync          <= 1'($urandom);
      sync_in.raw_vsync          <= 1'($urandom);
      sync_in.green_channel_sync <= 1'($urandom);
      sync_in.copy_protect_det   <= cp_en;
      // Pulses exist only on protected material
      sync_in.cp_pulse           <= cp_en & 1'($urandom);
      hsync_trailing             <= (pos_q == 2);
      clamp_pulse                <= (pos_q == 3);
    end
  end
endmodule // vafe_src_model

// ### bench/video_afe_sync_gain_offset_ctrl_tb.sv
/*
  Bench for vafe_ctrl: register bus, sync masking, staged gain, offset modes.
  Assumes vafe_pkg, vafe_defs.svh and vafe_src_model are compiled first.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, e, g); end end
module video_afe_sync_gain_offset_ctrl_tb;
  localparam int TMO = 50;
  logic                        clk = 1'b0;
  logic                        srst = 1'b1;
  logic [7:0]                  avs_address = 8'h00;
  logic                        avs_read = 1'b0;
  logic                        avs_write = 1'b0;
  logic [31:0]                 avs_writedata = 32'h0;
  logic [3:0]                  avs_byteenable = 4'h0;
  logic [31:0]                 avs_readdata;
  logic                        avs_waitrequest;
  logic                        clamp_pulse;
  logic                        hsync_trailing;
  logic                        run = 1'b0;
  logic                        cp_en = 1'b0;
  logic                        mon_en = 1'b0;
  logic [7:0]                  cfg_m = 8'h00;
  logic                        exp_pll = 1'b0;
  logic                        exp_hs = 1'b0;
  logic                        exp_vs = 1'b0;
  logic                        exp_lr = 1'b0;
  logic                        src;
  logic                        mask;
  logic [7:0]                  rd;
  logic [7:0]                  g;
  logic [7:0]                  old;
  logic [7:0]                  mdl [256] = '{default: 8'h00};
  logic [7:0]                  ofs [12] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A,
                                            8'h0B, 8'h0C, 8'h0D, 8'h13, 8'h17, 8'h1C};
  logic [7:0]                  rst_v [12] = '{8'h00, 8'h55, 8'h55, 8'h55, 8'h80, 8'h80,
                                              8'h80, 8'h00, 8'h0E, 8'h00, 8'h00, 8'h49};
  vafe_pkg::vafe_sync_in_type  sync_in;
  vafe_pkg::vafe_sync_out_type sync_out;
  vafe_pkg::vafe_gain_type     gain_active;
  vafe_pkg::vafe_offset_type   offset_ctl;
  vafe_pkg::vafe_analog_type   analog_ctl;
  int                          n_errors = 0;
  int                          n_tests = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  vafe_ctrl #(.GAIN_TIMEOUT_CYC(TMO)) dut (.clk(clk), .srst(srst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sync_in(sync_in),
    .clamp_pulse(clamp_pulse), .hsync_trailing(hsync_trailing), .sync_out(sync_out),
    .gain_active(gain_active), .offset_ctl(offset_ctl), .analog_ctl(analog_ctl));
  vafe_src_model src_m (.clk(clk), .srst(srst), .run(run), .cp_en(cp_en),
    .sync_in(sync_in), .clamp_pulse(clamp_pulse), .hsync_trailing(hsync_trailing));

  function automatic logic mapped(input logic [7:0] a);
    foreach (ofs[k]) if (ofs[k] == a) return 1'b1;
    return 1'b0;
  endfunction

  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [3:0] be);
    int i;
    @(posedge clk);
    avs_write      <= w;
    avs_read       <= !w;
    avs_address    <= a;
    avs_writedata  <= {24'h0, d};
    avs_byteenable <= be;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (avs_waitrequest !== 1'b0 && i < 20);
    `CHK("waitrequest", 1'b0, avs_waitrequest)
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (w && be[0] && mapped(a)) mdl[a] = d;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask

  task automatic rdchk(input logic [7:0] a);
    xfer(1'b0, a, 8'h00, 4'hF);
    `CHK("readback", mdl[a], rd)
  endtask

  // Derived controls are registered behind the registers: two edges after the write
  task automatic chk_derived();
    repeat (2) @(posedge clk);
    `CHK("bw corner", mdl[8'h0D][3:1], analog_ctl.bw_corner)
    `CHK("peaking", mdl[8'h0D][7:4], analog_ctl.peaking)
    `CHK("dpll gain", mdl[8'h1C], analog_ctl.dpll_gain)
    `CHK("ext clock", mdl[8'h13][5:4] == 2'h3, analog_ctl.ext_pixel_clk)
    `CHK("loop on", !mdl[8'h17][0], offset_ctl.loop_on)
    `CHK("range", mdl[8'h0C][0], offset_ctl.range_half)
    if (mdl[8'h17][0]) begin
      `CHK("dac", {mdl[8'h09], mdl[8'h0C][7:6], mdl[8'h0A], mdl[8'h0C][5:4], mdl[8'h0B],
        mdl[8'h0C][3:2]}, {offset_ctl.red_dac, offset_ctl.green_dac, offset_ctl.blue_dac})
      `CHK("digital off", 24'h0, {offset_ctl.red_digital, offset_ctl.green_digital,
        offset_ctl.blue_digital})
    end else begin
      `CHK("digital", {mdl[8'h09], mdl[8'h0A], mdl[8'h0B]}, {offset_ctl.red_digital,
        offset_ctl.green_digital, offset_ctl.blue_digital})
    end
  endtask

  task automatic setcfg(input logic [7:0] d);
    mon_en <= 1'b0;
    wr(8'h05, d);
    cfg_m = d;
    repeat (2) @(posedge clk);
    mon_en <= 1'b1;
  endtask

  // Compare last edge's prediction, then predict from this edge's inputs
  always @(posedge clk) begin
    if (mon_en) begin
      `CHK("pll sync", exp_pll, sync_out.pll_sync)
      `CHK("hsync out", exp_hs, sync_out.hsync_out)
      `CHK("vsync out", exp_vs, sync_out.vsync_out)
      `CHK("loop run", exp_lr, analog_ctl.loop_run)
    end
    exp_vs = sync_in.raw_vsync;
    exp_lr = hsync_trailing & !mdl[8'h17][0];
    src = (cfg_m[4:3] == 2'h2) ? sync_in.green_channel_sync : sync_in.raw_hsync;
    mask = sync_in.copy_protect_det & sync_in.cp_pulse & !cfg_m[6];
    exp_pll = src & !mask;
    exp_hs = src & !(mask & !cfg_m[7]);
  end

  task automatic complete_run();
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #(20000 * 10);
    n_errors++;
    complete_run();
  end

  initial begin
    void'($urandom(32'h9ad4deef));
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    foreach (ofs[k]) mdl[ofs[k]] = rst_v[k];
    foreach (ofs[k]) rdchk(ofs[k]);
    `CHK("gain reset", 24'h555555, gain_active)
    for (int i = 0; i < 16; i++) begin
      wr(8'h0D, {4'(i), 3'(i), 1'(i >> 3)});
      wr(8'h13, {2'h0, 2'(i), 4'h0});
      wr(8'h17, {7'h0, 1'(i >> 1)});
      wr(8'h0C, {7'($urandom), 1'(i >> 2)});
      for (int c = 9; c < 12; c++) wr(8'(c), 8'($urandom));
      chk_derived();
    end
    wr(8'h0D, 8'h20);
    wr(8'h1C, 8'h4C);
    chk_derived();
    wr(8'h3F, 8'($urandom));
    rdchk(8'h3F);
    xfer(1'b1, 8'h09, ~mdl[8'h09], 4'h0);
    rdchk(8'h09);
    old = 8'h55;
    g = old ^ 8'($urandom | 1);
    wr(8'h06, g);
    repeat (20) @(posedge clk);
    `CHK("gain staged", old, gain_active.red)
    run <= 1'b1;
    for (int i = 0; i < 40 && clamp_pulse !== 1'b1; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    `CHK("gain on clamp", g, gain_active.red)
    run <= 1'b0;
    old = 8'h55;
    g = old ^ 8'h5A;
    wr(8'h07, g);
    repeat (40) @(posedge clk);
    `CHK("gain pending", old, gain_active.green)
    repeat (20) @(posedge clk);
    `CHK("gain timeout", g, gain_active.green)
    wr(8'h17, 8'h00);
    run <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      setcfg({3'h0, 2'(s), 3'h0});
      repeat (30) @(posedge clk);
    end
    cp_en <= 1'b1;
    foreach (ofs[k]) if (k < 3) begin
      setcfg(8'h10 | (8'h40 << k) & 8'hC0);
      repeat (40) @(posedge clk);
    end
    mon_en <= 1'b0;
    complete_run();
  end
endmodule // video_afe_sync_gain_offset_ctrl_tb
